/* dv/dvp_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module dvp_regs_checker
   import dvp_pkg::*;
(
   input wire logic                                        core_clk,         // Clock.
   input wire logic                                        sys_rst,          // Reset.
   input wire logic [7:0]                                  reg_addr,         // Address.
   input wire logic [7:0]                                  reg_wdata,        // Write data.
   input wire logic                                        reg_wr,           // Write strobe.
   input wire logic                                        reg_rd,           // Read strobe.
   input wire logic [7:0]                                  reg_rdata,        // Read data.
   input wire logic [DVP_NUM_ATT_CH-1:0][DVP_SAMPLE_W-1:0] ch_sample_in,     // Samples in.
   input wire logic [DVP_NUM_ATT_CH-1:0]                   ch_sample_valid,  // Input strobes.
   input wire logic [DVP_NUM_ATT_CH-1:0][DVP_SAMPLE_W-1:0] ch_sample_out,    // Samples out.
   input wire logic [DVP_NUM_ATT_CH-1:0]                   ch_out_valid,     // Output strobes.
   input wire logic [7:0]                                  ch9_attenuation,  // Code.
   input wire logic [7:0]                                  ch10_attenuation, // Code.
   input wire logic [7:0]                                  ch11_attenuation, // Code.
   input wire logic [7:0]                                  ch12_attenuation, // Code.
   input wire logic                                        pad_drive_select, // Pad drive.
   input wire logic [1:0]                                  ch1_power_mode,   // Field.
   input wire logic [1:0]                                  ch2_power_mode,   // Field.
   input wire logic [1:0]                                  ch3_power_mode,   // Field.
   input wire logic [1:0]                                  ch4_power_mode,   // Field.
   input wire logic [DVP_NUM_PWR_CH-1:0]                   pwr_low,          // Decode.
   input wire logic [DVP_NUM_PWR_CH-1:0]                   pwr_lowest,       // Decode.
   input wire logic [DVP_NUM_PWR_CH-1:0]                   pwr_best,         // Decode.
   input wire logic [DVP_NUM_PWR_CH-1:0]                   pwr_good          // Decode.
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire logic [7:0] pwr_word;
   assign pwr_word = {ch4_power_mode, ch3_power_mode, ch2_power_mode, ch1_power_mode};

   // ==========================================================================
   // Register port
   chk_read_power: assert property (
      reg_rd && reg_addr == DVP_ADDR_POWER1 |=> reg_rdata == pwr_word) else $error("power read wrong");
   chk_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == DVP_READ_IDLE) else $error("read data not idle");
   chk_att_write: assert property (
      reg_wr && reg_addr == DVP_ADDR_CH9_ATT |=> ch9_attenuation == $past(reg_wdata)) else $error("code not stored");
   chk_att_hold: assert property (
      !(reg_wr && reg_addr == DVP_ADDR_CH10_ATT) |=> $stable(ch10_attenuation)) else $error("code disturbed");
   chk_pad_write: assert property (
      reg_wr && reg_addr == DVP_ADDR_PAD_DRIVE |=> pad_drive_select == $past(reg_wdata[5])) else $error("pad bit");
   chk_pad_read: assert property (
      reg_rd && reg_addr == DVP_ADDR_PAD_DRIVE |=> reg_rdata == {2'b00, pad_drive_select, 5'b0_0000})
      else $error("pad read wrong");
   chk_power_lowest: assert property (
      1'b1 |-> pwr_lowest[3] == ($past(ch4_power_mode) == DVP_PWR_LOWEST)) else $error("lowest decode");
   chk_power_best: assert property (
      1'b1 |-> pwr_best[2] == ($past(ch3_power_mode) == DVP_PWR_BEST)) else $error("best decode");

   // ==========================================================================
   // Sample path
   chk_sample_latency: assert property (
      ch_sample_valid[0] |-> ##2 ch_out_valid[0]) else $error("output strobe late");
   chk_out_origin: assert property (
      ch_out_valid[1] |-> $past(ch_sample_valid[1], 2)) else $error("spurious output strobe");
   chk_unity_gain: assert property (
      ch_sample_valid[0] && ch9_attenuation == 8'h00 |-> ##2 ch_sample_out[0] == $past(ch_sample_in[0], 2))
      else $error("unity gain wrong");

   cov_power_read: cover property (reg_rd && reg_addr == DVP_ADDR_POWER1);
   cov_pad_write: cover property (reg_wr && reg_addr == DVP_ADDR_PAD_DRIVE);
   cov_sample: cover property (ch_sample_valid[0] ##2 ch_out_valid[0]);
endmodule : dvp_regs_checker

`default_nettype wire

/* dv/test_dac_volume_power_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module test_dac_volume_power_regs;
   import dvp_pkg::*;
   logic                                        core_clk, sys_rst, reg_wr, reg_rd, pad_drive_select;
   logic [7:0]                                  reg_addr, reg_wdata, reg_rdata, ch9_att, ch10_att, ch11_att, ch12_att;
   logic [DVP_NUM_ATT_CH-1:0][DVP_SAMPLE_W-1:0] ch_sample_in, ch_sample_out;
   logic [3:0]                                  ch_sample_valid, ch_out_valid, pwr_low, pwr_lowest, pwr_best, pwr_good;
   logic [1:0]                                  pm1, pm2, pm3, pm4;
   logic [7:0]                                  codes [4];
   int                                          n_errors = 0;
   int                                          checks = 0;

   dvp_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_sample_in(ch_sample_in),
      .ch_sample_valid(ch_sample_valid), .ch_sample_out(ch_sample_out), .ch_out_valid(ch_out_valid),
      .ch9_attenuation(ch9_att), .ch10_attenuation(ch10_att), .ch11_attenuation(ch11_att),
      .ch12_attenuation(ch12_att), .pad_drive_select(pad_drive_select), .ch1_power_mode(pm1),
      .ch2_power_mode(pm2), .ch3_power_mode(pm3), .ch4_power_mode(pm4), .pwr_low(pwr_low),
      .pwr_lowest(pwr_lowest), .pwr_best(pwr_best), .pwr_good(pwr_good));

   // ==========================================================================
   // Bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : rd_chk

   // Drives one sample into every channel and compares each result with the ideal gain.
   task automatic samp();
      real e;
      real d;
      @(posedge core_clk);
      ch_sample_in    <= {4{24'h40_0000}};
      ch_sample_valid <= 4'hF;
      @(posedge core_clk);
      ch_sample_valid <= 4'h0;
      @(posedge core_clk);
      #1 check(ch_out_valid, 4'hF);
      for (int i = 0; i < 4; i++) begin
         e = 4194304.0 * 10.0 ** (-DVP_ATT_STEP_DB * codes[i] / 20.0);
         d = $itor($signed(ch_sample_out[i])) - e;
         check(d <= 0.005 * e + 8.0 && d >= -(0.005 * e + 8.0), 1'b1);
         if (codes[i] == 8'h00) check(ch_sample_out[i], 24'h40_0000);
      end
   endtask : samp

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial begin
      #20000;
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done();
   end

   // ==========================================================================
   // Test sequence
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, ch_sample_in, ch_sample_valid} = '0;
      codes   = '{8'h00, 8'h00, 8'h00, 8'h00};
      sys_rst = 1'b1;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd_chk(DVP_ADDR_CH9_ATT + 8'(i), 8'h00);
      rd_chk(DVP_ADDR_PAD_DRIVE, 8'h00);
      rd_chk(DVP_ADDR_POWER1, 8'hAA);
      check(pwr_best, 4'hF);
      samp();
      $display("reset values test done");
      codes = '{8'hFF, 8'h01, 8'h10, 8'h3C};
      for (int i = 0; i < 4; i++) wr(DVP_ADDR_CH9_ATT + 8'(i), codes[i]);
      for (int i = 0; i < 4; i++) rd_chk(DVP_ADDR_CH9_ATT + 8'(i), codes[i]);
      check({ch12_att, ch11_att, ch10_att, ch9_att}, {codes[3], codes[2], codes[1], codes[0]});
      samp();
      $display("attenuation test done");
      wr(8'h18, 8'h55);
      rd_chk(8'h18, 8'h00);
      rd_chk(DVP_ADDR_CH12_ATT, 8'h3C);
      wr(DVP_ADDR_PAD_DRIVE, 8'hFF);
      rd_chk(DVP_ADDR_PAD_DRIVE, 8'h20);
      check(pad_drive_select, 1'b1);
      wr(DVP_ADDR_PAD_DRIVE, 8'hDF);
      rd_chk(DVP_ADDR_PAD_DRIVE, 8'h00);
      check(pad_drive_select, 1'b0);
      $display("pad drive test done");
      wr(DVP_ADDR_POWER1, 8'hE4);
      rd_chk(DVP_ADDR_POWER1, 8'hE4);
      check({pm4, pm3, pm2, pm1}, {2'h3, 2'h2, 2'h1, 2'h0});
      check({pwr_good, pwr_best, pwr_lowest, pwr_low}, 16'h8421);
      $display("power select test done");
      // A reset in mid-run must bring every written register back to its default.
      wr(DVP_ADDR_PAD_DRIVE, 8'h20);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd_chk(DVP_ADDR_CH9_ATT + 8'(i), 8'h00);
      rd_chk(DVP_ADDR_PAD_DRIVE, 8'h00);
      check(pad_drive_select, 1'b0);
      rd_chk(DVP_ADDR_POWER1, 8'hAA);
      check({pm4, pm3, pm2, pm1}, 8'hAA);
      check({pwr_good, pwr_best, pwr_lowest, pwr_low}, 16'h0F00);
      $display("mid-run reset test done");
      test_done();
   end
endmodule : test_dac_volume_power_regs

bind dvp_regs dvp_regs_checker chk_i (.*);

`default_nettype wire

/* logic/dvp_chan_atten.sv */
`timescale 1ns/1ps
`default_nettype none

module dvp_chan_atten
   import dvp_pkg::*;
(
   input  wire logic                           core_clk,      // System clock.
   input  wire logic                           sys_rst,       // Synchronous reset, active high.
   input  wire logic [7:0]                     att_code,      // Attenuation code for this channel.
   input  wire logic signed [DVP_SAMPLE_W-1:0] sample_in,     // Input sample.
   input  wire logic                           sample_valid,  // Input sample strobe.
   output logic signed [DVP_SAMPLE_W-1:0]      sample_out,    // Attenuated sample.
   output logic                                out_valid      // Output sample strobe.
);

   // ==========================================================================
   // Gain lookup: the code splits into whole 6 dB steps and 0.375 dB steps.
   wire  logic [16:0]                     fine_gain;
   wire  logic [16:0]                     coarse_gain;
   logic [3:0]                            coarse_idx_q;
   logic signed [DVP_SAMPLE_W-1:0]        stage1_q;
   logic                                  stage1_vld_q;
   wire  logic signed [DVP_SAMPLE_W+17:0] fine_prod;
   wire  logic signed [DVP_SAMPLE_W+17:0] coarse_prod;

   assign fine_gain   = DVP_FINE_GAIN[att_code[3:0]];
   assign coarse_gain = DVP_COARSE_GAIN[coarse_idx_q];
   assign fine_prod   = sample_in * $signed({1'b0, fine_gain});
   assign coarse_prod = stage1_q * $signed({1'b0, coarse_gain});

   // ==========================================================================
   // Two multiply stages; the code is caught with the sample so it stays paired.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stage1_q     <= '0;
         coarse_idx_q <= 4'h0;
         stage1_vld_q <= 1'b0;
         sample_out   <= '0;
         out_valid    <= 1'b0;
      end else begin
         stage1_vld_q <= sample_valid;
         out_valid    <= stage1_vld_q;
         if (sample_valid) begin
            stage1_q     <= fine_prod[DVP_GAIN_FRAC +: DVP_SAMPLE_W];
            coarse_idx_q <= att_code[7:4];
         end
         if (stage1_vld_q) begin
            sample_out <= coarse_prod[DVP_GAIN_FRAC +: DVP_SAMPLE_W];
         end
      end
   end

endmodule : dvp_chan_atten

`default_nettype wire

/* logic/dvp_pkg.sv */
// Summary of operation
// - Each attenuation code step adds 0.375 dB.
// - Code zero is 0 dB; all-ones 95.625 dB.
// - Channel 9 to 12 attenuation at consecutive addresses.
// - Attenuation registers reset zero, full read/write.
// - Pad bit 5 selects 4 or 8 mA.
// - Pad register own address, resets to zero.
// - Power register own address, resets to 0xAA.
// - Channel 4..1 fields at bits 7:6..1:0.
// - Power codes: low, lowest, best, good.
// - Every power field resets to best performance.
`default_nettype none

package dvp_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] DVP_ADDR_CH9_ATT   = 8'h14;
   localparam logic [7:0] DVP_ADDR_CH10_ATT  = 8'h15;
   localparam logic [7:0] DVP_ADDR_CH11_ATT  = 8'h16;
   localparam logic [7:0] DVP_ADDR_CH12_ATT  = 8'h17;
   localparam logic [7:0] DVP_ADDR_PAD_DRIVE = 8'h1C;
   localparam logic [7:0] DVP_ADDR_POWER1    = 8'h1D;

   // ==========================================================================
   // Reset values and field layout
   localparam logic [7:0] DVP_ATT_RST        = 8'h00;
   localparam logic [7:0] DVP_PAD_RST        = 8'h00;
   localparam logic [7:0] DVP_POWER1_RST     = 8'hAA;
   localparam logic [7:0] DVP_READ_IDLE      = 8'h00;
   localparam int         DVP_PAD_DRIVE_SELECT_BIT    = 5;
   localparam int         DVP_PWR_FIELD_W    = 2;
   localparam int         DVP_NUM_ATT_CH     = 4;
   localparam int         DVP_NUM_PWR_CH     = 4;
   localparam int         DVP_SAMPLE_W       = 24;
   localparam int         DVP_GAIN_W         = 17;
   localparam int         DVP_GAIN_FRAC      = 16;

   // ==========================================================================
   // Attenuation step and the gain tables derived from it
   localparam real        DVP_ATT_STEP_DB    = 0.375;
   localparam real        DVP_ATT_MAX_DB     = 95.625;

   // Gain for the low nibble: 10^(-0.375*n/20), unsigned with 16 fraction bits.
   localparam logic [16:0] DVP_FINE_GAIN [16] = '{
      17'h1_0000, 17'h0_F52F, 17'h0_EAD3, 17'h0_E0E6,
      17'h0_D766, 17'h0_CE4C, 17'h0_C595, 17'h0_BD3B,
      17'h0_B53C, 17'h0_AD94, 17'h0_A63E, 17'h0_9F38,
      17'h0_987D, 17'h0_920C, 17'h0_8BE0, 17'h0_85F7};

   // Gain for the high nibble: 10^(-6*n/20), one 6 dB step per entry.
   localparam logic [16:0] DVP_COARSE_GAIN [16] = '{
      17'h1_0000, 17'h0_804E, 17'h0_404E, 17'h0_203A,
      17'h0_1027, 17'h0_0818, 17'h0_040F, 17'h0_0209,
      17'h0_0105, 17'h0_0083, 17'h0_0042, 17'h0_0021,
      17'h0_0010, 17'h0_0008, 17'h0_0004, 17'h0_0002};

   // ==========================================================================
   // Power field encodings
   typedef enum logic [1:0] {
      DVP_PWR_LOW    = 2'h0,
      DVP_PWR_LOWEST = 2'h1,
      DVP_PWR_BEST   = 2'h2,
      DVP_PWR_GOOD   = 2'h3
   } dvp_power_mode_t;

endpackage : dvp_pkg

`default_nettype wire

/* logic/dvp_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module dvp_regs
   import dvp_pkg::*;
(
   input  wire logic                                          core_clk,        // System clock, 200 MHz.
   input  wire logic                                          sys_rst,         // Synchronous reset, active high.
   input  wire logic [7:0]                                    reg_addr,        // Register address.
   input  wire logic [7:0]                                    reg_wdata,       // Register write data.
   input  wire logic                                          reg_wr,          // Write strobe.
   input  wire logic                                          reg_rd,          // Read strobe.
   output logic [7:0]                                         reg_rdata,       // Read data, cycle after strobe.
   input  wire logic [DVP_NUM_ATT_CH-1:0][DVP_SAMPLE_W-1:0]   ch_sample_in,    // Channel 9..12 samples in.
   input  wire logic [DVP_NUM_ATT_CH-1:0]                     ch_sample_valid, // Channel 9..12 input strobes.
   output logic [DVP_NUM_ATT_CH-1:0][DVP_SAMPLE_W-1:0]        ch_sample_out,   // Channel 9..12 samples out.
   output logic [DVP_NUM_ATT_CH-1:0]                          ch_out_valid,    // Channel 9..12 output strobes.
   output logic [7:0]                                         ch9_attenuation,  // Channel 9 code.
   output logic [7:0]                                         ch10_attenuation, // Channel 10 code.
   output logic [7:0]                                         ch11_attenuation, // Channel 11 code.
   output logic [7:0]                                         ch12_attenuation, // Channel 12 code.
   output logic                                               pad_drive_select, // 0: 4 mA, 1: 8 mA.
   output logic [1:0]                                         ch1_power_mode,   // Channel 1 power field.
   output logic [1:0]                                         ch2_power_mode,   // Channel 2 power field.
   output logic [1:0]                                         ch3_power_mode,   // Channel 3 power field.
   output logic [1:0]                                         ch4_power_mode,   // Channel 4 power field.
   output logic [DVP_NUM_PWR_CH-1:0]                          pwr_low,          // Low power, per channel.
   output logic [DVP_NUM_PWR_CH-1:0]                          pwr_lowest,       // Lowest power, per channel.
   output logic [DVP_NUM_PWR_CH-1:0]                          pwr_best,         // Best performance, per channel.
   output logic [DVP_NUM_PWR_CH-1:0]                          pwr_good          // Good performance, per channel.
);

   // ==========================================================================
   // Register storage
   logic [DVP_NUM_ATT_CH-1:0][7:0] att_q;
   logic                           pad_drive_select_q;
   logic [7:0]                     power1_q;

   // ==========================================================================
   // Address decode
   wire logic                      hit_ch9;
   wire logic                      hit_ch10;
   wire logic                      hit_ch11;
   wire logic                      hit_ch12;
   wire logic                      hit_pad;
   wire logic                      hit_power1;
   wire logic [DVP_NUM_ATT_CH-1:0] att_hit;
   wire logic [DVP_NUM_ATT_CH-1:0] att_we;
   wire logic                      pad_we;
   wire logic                      power1_we;

   assign hit_ch9    = (reg_addr == DVP_ADDR_CH9_ATT);
   assign hit_ch10   = (reg_addr == DVP_ADDR_CH10_ATT);
   assign hit_ch11   = (reg_addr == DVP_ADDR_CH11_ATT);
   assign hit_ch12   = (reg_addr == DVP_ADDR_CH12_ATT);
   assign hit_pad    = (reg_addr == DVP_ADDR_PAD_DRIVE);
   assign hit_power1 = (reg_addr == DVP_ADDR_POWER1);
   assign att_hit    = {hit_ch12, hit_ch11, hit_ch10, hit_ch9};
   assign att_we     = att_hit & {DVP_NUM_ATT_CH{reg_wr}};
   assign pad_we     = hit_pad & reg_wr;
   assign power1_we  = hit_power1 & reg_wr;

   // ==========================================================================
   // Read data selection
   wire logic [7:0] pad_read_val;
   wire logic [7:0] read_mux;

   // Only the drive bit exists; every other pad bit reads as zero.
   assign pad_read_val = 8'(pad_drive_select_q) << DVP_PAD_DRIVE_SELECT_BIT;

   assign read_mux = hit_ch9    ? att_q[0]     :
                     hit_ch10   ? att_q[1]     :
                     hit_ch11   ? att_q[2]     :
                     hit_ch12   ? att_q[3]     :
                     hit_pad    ? pad_read_val :
                     hit_power1 ? power1_q     :
                                  DVP_READ_IDLE;

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= DVP_READ_IDLE;
      end else begin
         reg_rdata <= reg_rd ? read_mux : DVP_READ_IDLE;
      end
   end

   // ==========================================================================
   // Attenuation registers, one per channel
   genvar gi;
   generate
      for (gi = 0; gi < DVP_NUM_ATT_CH; gi++) begin : g_att
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               att_q[gi] <= DVP_ATT_RST;
            end else if (att_we[gi]) begin
               att_q[gi] <= reg_wdata;
            end
         end

         // Each channel has its own datapath, so a code change touches no other.
         dvp_chan_atten u_atten (
            .core_clk     (core_clk),
            .sys_rst      (sys_rst),
            .att_code     (att_q[gi]),
            .sample_in    (ch_sample_in[gi]),
            .sample_valid (ch_sample_valid[gi]),
            .sample_out   (ch_sample_out[gi]),
            .out_valid    (ch_out_valid[gi])
         );
      end
   endgenerate

   assign ch9_attenuation  = att_q[0];
   assign ch10_attenuation = att_q[1];
   assign ch11_attenuation = att_q[2];
   assign ch12_attenuation = att_q[3];

   // ==========================================================================
   // Pad drive and power registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pad_drive_select_q <= DVP_PAD_RST[DVP_PAD_DRIVE_SELECT_BIT];
         power1_q  <= DVP_POWER1_RST;
      end else begin
         if (pad_we) begin
            pad_drive_select_q <= reg_wdata[DVP_PAD_DRIVE_SELECT_BIT];
         end
         if (power1_we) begin
            power1_q <= reg_wdata;
         end
      end
   end

   assign pad_drive_select = pad_drive_select_q;
   assign ch1_power_mode   = power1_q[1:0];
   assign ch2_power_mode   = power1_q[3:2];
   assign ch3_power_mode   = power1_q[5:4];
   assign ch4_power_mode   = power1_q[7:6];

   // ==========================================================================
   // Power mode decode, registered per channel
   wire logic [DVP_NUM_PWR_CH-1:0] low_d;
   wire logic [DVP_NUM_PWR_CH-1:0] lowest_d;
   wire logic [DVP_NUM_PWR_CH-1:0] best_d;
   wire logic [DVP_NUM_PWR_CH-1:0] good_d;

   generate
      for (gi = 0; gi < DVP_NUM_PWR_CH; gi++) begin : g_pwr
         wire logic [1:0] field;
         assign field        = power1_q[gi*DVP_PWR_FIELD_W +: DVP_PWR_FIELD_W];
         assign low_d[gi]    = (field == DVP_PWR_LOW);
         assign lowest_d[gi] = (field == DVP_PWR_LOWEST);
         assign best_d[gi]   = (field == DVP_PWR_BEST);
         assign good_d[gi]   = (field == DVP_PWR_GOOD);
      end
   endgenerate

   // After reset every channel shows best performance, matching the register.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pwr_low    <= '0;
         pwr_lowest <= '0;
         pwr_best   <= '1;
         pwr_good   <= '0;
      end else begin
         pwr_low    <= low_d;
         pwr_lowest <= lowest_d;
         pwr_best   <= best_d;
         pwr_good   <= good_d;
      end
   end

endmodule : dvp_regs

`default_nettype wire
